// [rtl/ove_pkg.sv]
// Shared constants and types for the overvoltage event recorder
package ove_pkg;

  localparam int CLK_HZ_DEF    = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;

  // Percent timer base tick, 0.1 ms
  localparam int BASE_TICK_NS  = 100_000;
  localparam int BASE_TICK_CYC = (BASE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Time stamp tick, 1 ms
  localparam int MS_TICK_NS    = 1_000_000;
  localparam int MS_TICK_CYC   = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int TS_WRAP_MS    = 60_000;
  localparam int MON_TIMEOUT_MS = 1000;

  localparam int BAUD_300  = 300;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h4;
  localparam logic [2:0] BAUD_SEL_DEF = 3'h4;

  localparam logic [4:0] A_CTRL  = 5'h00;
  localparam logic [4:0] A_MAXV  = 5'h01;
  localparam logic [4:0] A_NLOW  = 5'h02;
  localparam logic [4:0] A_NHIGH = 5'h03;
  localparam logic [4:0] A_DLOW  = 5'h04;
  localparam logic [4:0] A_DHIGH = 5'h05;
  localparam logic [4:0] A_NODE  = 5'h0a;
  localparam logic [4:0] A_BAUD  = 5'h0b;
  localparam logic [4:0] A_MON   = 5'h0c;
  localparam logic [4:0] A_MASK  = 5'h0d;
  localparam logic [4:0] A_CLEAR = 5'h0e;
  localparam logic [4:0] A_EVT   = 5'h0f;
  localparam logic [4:0] A_PASS  = 5'h10;
  localparam logic [4:0] A_TLOW  = 5'h11;
  localparam logic [4:0] A_THIGH = 5'h12;

  localparam int TEST_SEL_LSB  = 12;
  localparam int TSET_RNG_LSB  = 8;
  localparam int EVT_VALID_BIT = 31;

  localparam logic [7:0]  MASK_DEF  = 8'h55;
  localparam logic [7:0]  NODE_DEF  = 8'h01;
  localparam logic [15:0] PASS_DEF  = 16'h0000;
  localparam logic [9:0]  TSET_DEF  = 10'h005;
  localparam logic [6:0]  PCT_FULL  = 7'h64;
  localparam logic [6:0]  PCT_LAST  = 7'h63;

  localparam logic [5:0] CODE_RESTART  = 6'h32;
  localparam logic [5:0] CODE_OVERFLOW = 6'h33;

  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [5:0]  code;
    logic [15:0] ts;
  } evt_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage

// [rtl/overvoltage_event_recorder.sv]
// Records, control display, serial settings and event queue of a two-stage overvoltage module
// How it works
// - Low stage start duration in percent
// - High stage start duration in percent
// - Display low digit encodes blocking state
// - Display middle digit always zero
// - Display top digit shows remote reset
// - Test mode forces outputs one at a time
// - Node address zero disables serial link
// - Baud selectable, default 9600
// - Bus monitor zero active, scrolls when lost
// - Buttons or command clear five records
// - Records lost, node/baud/password retained
// - Event mask enables events by weight
// - Mask range 0 to 255, default 85
// - Mask bits map stage start/trip/resets
// - Restart and overflow events never masked
// - Overflow event when queue overflows
// - Events carry millisecond time stamp
// - Operate timer has three ranges
// - Start counters per stage, 0 to 255
`timescale 1ns/1ps
module overvoltage_event_recorder
  import ove_pkg::*;
#(
  parameter int CLK_HZ      = ove_pkg::CLK_HZ_DEF,
  parameter int MS_CYCLES   = ove_pkg::MS_TICK_CYC
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             nv_rst_n,
  input  wire ove_pkg::bus_req_t bus,
  output logic [31:0]           rdata,
  input  wire logic [1:0]       stage_start,
  input  wire logic [7:0]       u0_level,
  input  wire logic [1:0]       block_pin,
  input  wire logic             remote_reset_pin,
  input  wire logic             step_btn_pin,
  input  wire logic             reset_btn_pin,
  input  wire logic             frame_ok,
  output logic [1:0]            start_out,
  output logic [1:0]            trip_out,
  output logic                  serial_en,
  output logic                  baud_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and time bases
  logic [4:0]  pin_s1_r;
  logic [4:0]  pin_s2_r;
  logic        both_prev_r;
  logic [11:0] base_cnt_r;
  logic [14:0] ms_cnt_r;
  logic [15:0] ts_r;
  // Tenth of the ms period, so a shortened ms scales the percent timers too
  wire         base_tick = (base_cnt_r == 12'(MS_CYCLES / (MS_TICK_NS / BASE_TICK_NS) - 1));
  wire         ms_tick   = (ms_cnt_r == 15'(MS_CYCLES - 1));
  wire [1:0]   blk       = pin_s2_r[1:0];
  wire         remote_rst = pin_s2_r[2];
  wire         both_btn  = pin_s2_r[3] & pin_s2_r[4];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r    <= 5'h00;
      pin_s2_r    <= 5'h00;
      both_prev_r <= 1'b0;
      base_cnt_r  <= 12'h000;
      ms_cnt_r    <= 15'h0000;
      ts_r        <= 16'h0000;
    end
    else
    begin
      pin_s1_r    <= {reset_btn_pin, step_btn_pin, remote_reset_pin, block_pin};
      pin_s2_r    <= pin_s1_r;
      both_prev_r <= both_btn;
      base_cnt_r  <= base_tick ? 12'h000 : base_cnt_r + 12'h001;
      ms_cnt_r    <= ms_tick ? 15'h0000 : ms_cnt_r + 15'h0001;
      if (ms_tick)
        ts_r <= (ts_r == 16'(TS_WRAP_MS - 1)) ? 16'h0000 : ts_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register strobes
  wire wr_ctrl  = bus.wr && bus.addr == A_CTRL;
  wire wr_node  = bus.wr && bus.addr == A_NODE;
  wire wr_baud  = bus.wr && bus.addr == A_BAUD;
  wire wr_mask  = bus.wr && bus.addr == A_MASK;
  wire wr_pass  = bus.wr && bus.addr == A_PASS;
  wire wr_tlow  = bus.wr && bus.addr == A_TLOW;
  wire wr_thigh = bus.wr && bus.addr == A_THIGH;
  wire rd_evt   = bus.rd && bus.addr == A_EVT;
  wire clear_rec = (bus.wr && bus.addr == A_CLEAR) || (both_btn && !both_prev_r);

  // Retained settings sit on the supply-independent reset only
  logic [7:0]  node_r;
  logic [2:0]  baud_r;
  logic [15:0] pass_r;

  always_ff @(posedge clk or negedge nv_rst_n)
  begin
    if (!nv_rst_n)
    begin
      node_r <= NODE_DEF;
      baud_r <= BAUD_SEL_DEF;
      pass_r <= PASS_DEF;
    end
    else
    begin
      if (wr_node)
        node_r <= bus.wdata[7:0];
      if (wr_baud && bus.wdata[2:0] <= BAUD_SEL_MAX)
        baud_r <= bus.wdata[2:0];
      if (wr_pass)
        pass_r <= bus.wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings on the ordinary reset
  logic [7:0] mask_r;
  logic [2:0] test_sel_r;
  logic [9:0] tset_r [2];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_r     <= MASK_DEF;
      test_sel_r <= 3'h0;
      tset_r[0]  <= TSET_DEF;
      tset_r[1]  <= TSET_DEF;
    end
    else
    begin
      if (wr_mask)
        mask_r <= bus.wdata[7:0];
      if (wr_ctrl)
        test_sel_r <= bus.wdata[TEST_SEL_LSB +: 3];
      if (wr_tlow)
        tset_r[0] <= bus.wdata[9:0];
      if (wr_thigh)
        tset_r[1] <= bus.wdata[9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-stage operate timer, percent record, start counter, event edges
  logic [6:0]  pct_r   [2];
  logic [13:0] sub_r   [2];
  logic [7:0]  nstart_r [2];
  logic [1:0]  op_r;
  logic [1:0]  start_prev_r;
  logic [1:0]  op_prev_r;
  logic [7:0]  ev_edge;

  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_stage
      wire [1:0]  rng  = tset_r[s][TSET_RNG_LSB +: 2];
      wire [13:0] tv   = 14'(tset_r[s][6:0]);
      // One percent of the operate time, counted in 0.1 ms ticks
      wire [13:0] step = (rng == 2'h0) ? tv :
                         (rng == 2'h1) ? 14'(tv * 14'd10) : 14'(tv * 14'd100);
      wire        rise = stage_start[s] && !start_prev_r[s];
      wire        done = (sub_r[s] + 14'h0001) >= step;

      assign ev_edge[4*s]     = rise;
      assign ev_edge[4*s + 1] = !stage_start[s] && start_prev_r[s];
      assign ev_edge[4*s + 2] = op_r[s] && !op_prev_r[s];
      assign ev_edge[4*s + 3] = !op_r[s] && op_prev_r[s];

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pct_r[s]    <= 7'h00;
          sub_r[s]    <= 14'h0000;
          nstart_r[s] <= 8'h00;
          op_r[s]     <= 1'b0;
        end
        else if (clear_rec)
        begin
          pct_r[s]    <= 7'h00;
          sub_r[s]    <= 14'h0000;
          nstart_r[s] <= 8'h00;
          op_r[s]     <= op_r[s] && stage_start[s];
        end
        else if (rise)
        begin
          pct_r[s]    <= 7'h00;
          sub_r[s]    <= 14'h0000;
          nstart_r[s] <= nstart_r[s] + 8'h01;
        end
        else if (!stage_start[s])
        begin
          op_r[s]  <= 1'b0;
          sub_r[s] <= 14'h0000;
        end
        else if (base_tick && !op_r[s])
        begin
          sub_r[s] <= done ? 14'h0000 : sub_r[s] + 14'h0001;
          if (done && pct_r[s] < PCT_LAST)
            pct_r[s] <= pct_r[s] + 7'h01;
          else if (done && !blk[s])
          begin
            pct_r[s] <= PCT_FULL;
            op_r[s]  <= 1'b1;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Maximum level, outputs with test forcing, serial side
  logic [7:0]  maxv_r;
  logic [15:0] quiet_r;
  logic [7:0]  mon_r;
  logic [16:0] baud_cnt_r;
  wire  frame_acc  = frame_ok && node_r != 8'h00;
  wire  link_up    = node_r != 8'h00 && quiet_r < 16'(MON_TIMEOUT_MS);
  wire [16:0] baud_div = (baud_r == 3'h0) ? 17'(CLK_HZ / BAUD_300)  :
                         (baud_r == 3'h1) ? 17'(CLK_HZ / BAUD_1200) :
                         (baud_r == 3'h2) ? 17'(CLK_HZ / BAUD_2400) :
                         (baud_r == 3'h3) ? 17'(CLK_HZ / BAUD_4800) :
                                            17'(CLK_HZ / BAUD_9600);
  wire  baud_wrap  = baud_cnt_r >= baud_div - 17'h00001;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      maxv_r     <= 8'h00;
      start_out  <= 2'h0;
      trip_out   <= 2'h0;
      start_prev_r <= 2'h0;
      op_prev_r  <= 2'h0;
      serial_en  <= 1'b0;
      baud_tick  <= 1'b0;
      baud_cnt_r <= 17'h00000;
      quiet_r    <= 16'(MON_TIMEOUT_MS);
      mon_r      <= 8'h00;
    end
    else
    begin
      start_prev_r <= stage_start;
      op_prev_r    <= op_r;
      if (clear_rec)
        maxv_r <= 8'h00;
      else if (u0_level > maxv_r || (|ev_edge[2] || |ev_edge[6]))
        maxv_r <= u0_level;
      // Test mode overrides the live outputs, one output per selection 1 to 4, none for 5 to 7
      start_out <= (test_sel_r == 3'h0) ? stage_start :
                   {test_sel_r == 3'h3, test_sel_r == 3'h1};
      trip_out  <= (test_sel_r == 3'h0) ? op_r :
                   {test_sel_r == 3'h4, test_sel_r == 3'h2};
      serial_en <= node_r != 8'h00;
      baud_cnt_r <= (baud_wrap || !serial_en) ? 17'h00000 : baud_cnt_r + 17'h00001;
      baud_tick  <= baud_wrap && serial_en;
      if (frame_acc)
        quiet_r <= 16'h0000;
      else if (ms_tick && quiet_r < 16'(MON_TIMEOUT_MS))
        quiet_r <= quiet_r + 16'h0001;
      if (link_up)
        mon_r <= 8'h00;
      else if (ms_tick)
        mon_r <= mon_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event pending flags and queue
  logic [7:0] pend_r;
  logic       rst_pend_r;
  logic       ovf_pend_r;
  evt_t       fifo_r [FIFO_DEPTH];
  logic [2:0] wr_ptr_r;
  logic [2:0] rd_ptr_r;
  logic [3:0] cnt_r;
  logic [7:0] lowest;
  logic [5:0] low_code;

  always_comb
  begin
    lowest   = 8'h00;
    low_code = 6'h00;
    for (int i = 7; i >= 0; i--)
      if (pend_r[i])
      begin
        lowest   = 8'h01 << i;
        low_code = 6'(i + 1);
      end
  end

  // Mask sampled when the edge is seen, so a later write leaves queued events alone
  wire [7:0] new_ev   = ev_edge & mask_r;
  wire       full     = cnt_r == 4'(FIFO_DEPTH);
  wire       pop      = rd_evt && cnt_r != 4'h0;
  wire       any_pend = ovf_pend_r || rst_pend_r || pend_r != 8'h00;
  wire       push     = any_pend && !full;
  wire [5:0] push_code = ovf_pend_r ? CODE_OVERFLOW :
                         rst_pend_r ? CODE_RESTART : low_code;
  wire       collide  = (new_ev & pend_r) != 8'h00;
  wire       lost     = (full && pend_r != 8'h00) || collide;
  wire [7:0] pend_clr = full ? pend_r : ((push && !ovf_pend_r && !rst_pend_r) ? lowest : 8'h00);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r     <= 8'h00;
      rst_pend_r <= 1'b1;
      ovf_pend_r <= 1'b0;
      wr_ptr_r   <= 3'h0;
      rd_ptr_r   <= 3'h0;
      cnt_r      <= 4'h0;
    end
    else
    begin
      pend_r <= (pend_r & ~pend_clr) | new_ev; // New edge wins over the clear
      if (lost)
        ovf_pend_r <= 1'b1;
      else if (push && ovf_pend_r)
        ovf_pend_r <= 1'b0;
      if (push && !ovf_pend_r && rst_pend_r)
        rst_pend_r <= 1'b0;
      if (push)
        wr_ptr_r <= wr_ptr_r + 3'h1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 3'h1;
      cnt_r <= cnt_r + {3'h0, push} - {3'h0, pop};
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      fifo_r[wr_ptr_r] <= '{code: push_code, ts: ts_r};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  wire [11:0] display = {3'h0, remote_rst, 4'h0, 2'h0, blk};
  wire evt_valid = cnt_r != 4'h0;
  evt_t head;
  assign head = fifo_r[rd_ptr_r];
  wire [31:0] rd_mux =
    (bus.addr == A_CTRL)  ? {17'h0, test_sel_r, display} :
    (bus.addr == A_MAXV)  ? {24'h0, maxv_r} :
    (bus.addr == A_NLOW)  ? {24'h0, nstart_r[0]} :
    (bus.addr == A_NHIGH) ? {24'h0, nstart_r[1]} :
    (bus.addr == A_DLOW)  ? {25'h0, pct_r[0]} :
    (bus.addr == A_DHIGH) ? {25'h0, pct_r[1]} :
    (bus.addr == A_NODE)  ? {24'h0, node_r} :
    (bus.addr == A_BAUD)  ? {29'h0, baud_r} :
    (bus.addr == A_MON)   ? {24'h0, mon_r} :
    (bus.addr == A_MASK)  ? {24'h0, mask_r} :
    (bus.addr == A_EVT)   ? {evt_valid, 9'h0, evt_valid ? head : 22'h0} :
    (bus.addr == A_PASS)  ? {16'h0, pass_r} :
    (bus.addr == A_TLOW)  ? {22'h0, tset_r[0]} :
    (bus.addr == A_THIGH) ? {22'h0, tset_r[1]} : 32'h0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else
      rdata <= bus.rd ? rd_mux : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  block_digit_a: assert property (bus.rd && bus.addr == A_CTRL |=> rdata[3:0] == {2'h0, $past(blk)})
    else $error("blocking digit wrong");
  mid_digit_a: assert property (bus.rd && bus.addr == A_CTRL |=> rdata[7:4] == 4'h0)
    else $error("middle digit not zero");
  remote_digit_a: assert property (bus.rd && bus.addr == A_CTRL |=> rdata[8] == $past(remote_rst))
    else $error("remote reset digit wrong");
  start_clear_a: assert property ($rose(stage_start[0]) && !clear_rec |=> pct_r[0] == 7'h00)
    else $error("low duration not cleared on start");
  high_full_a: assert property ($rose(op_r[1]) |-> pct_r[1] == PCT_FULL)
    else $error("high duration not 100 at operate");
  test_force_a: assert property (test_sel_r == 3'h2 && $stable(test_sel_r) |=> trip_out == 2'h1)
    else $error("test force wrong");
  node_off_a: assert property (node_r == 8'h00 |=> !serial_en ##1 !baud_tick)
    else $error("link active at node zero");
  baud_range_a: assert property (baud_r <= BAUD_SEL_MAX)
    else $error("baud selection out of range");
  mon_zero_a: assert property (link_up |=> mon_r == 8'h00)
    else $error("monitor not zero while link up");
  clear_rec_a: assert property (clear_rec |=> nstart_r[0] == 8'h00 && maxv_r == 8'h00 && pct_r[1] == 7'h00)
    else $error("records not cleared");
  mask_block_a: assert property (ev_edge[1] && !mask_r[1] && !pend_r[1] |=> !pend_r[1])
    else $error("masked event became pending");
  start_count_a: assert property ($rose(stage_start[1]) && !clear_rec |=> nstart_r[1] == $past(nstart_r[1]) + 8'h01)
    else $error("high start count wrong");
  overflow_a: assert property (lost |=> ovf_pend_r)
    else $error("overflow not flagged");

endmodule

// [test/station_model.sv]
// Station communicator model: register port master and frame source
`timescale 1ns/1ps
module station_model
(
  input  wire logic         clk,
  input  wire logic [31:0]  rdata,
  output ove_pkg::bus_req_t bus,
  output logic              frame_ok
);
  import ove_pkg::*;

  // Link loss events stay on this side, never sent to the module
  initial
  begin
    bus = '0;
    frame_ok = 1'b0;
  end

  //////////////////////////////////////////////////
  // Released lines show inverted data, not the last value
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.addr <= ~a;
    bus.wdata <= ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    bus.addr <= ~a;
    #1;
    q = rdata;
  endtask

  task automatic frame;
    @(posedge clk);
    frame_ok <= 1'b1;
    @(posedge clk);
    frame_ok <= 1'b0;
  endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the overvoltage event recorder
`timescale 1ns/1ps
module tb;
  import ove_pkg::*;
  localparam int MSC = 250;
  localparam int HZ  = 96000;
  logic        clk, rst_n, nv_rst_n, frame_ok, remote_reset_pin;
  logic        step_btn_pin, reset_btn_pin, serial_en, baud_tick, ovf;
  logic [1:0]  stage_start, block_pin, start_out, trip_out;
  logic [7:0]  u0_level, seen;
  logic [31:0] rdata, q;
  bus_req_t    bus;
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;

  overvoltage_event_recorder #(.CLK_HZ(HZ), .MS_CYCLES(MSC)) dut (
    .clk(clk), .rst_n(rst_n), .nv_rst_n(nv_rst_n), .bus(bus), .rdata(rdata),
    .stage_start(stage_start), .u0_level(u0_level), .block_pin(block_pin),
    .remote_reset_pin(remote_reset_pin), .step_btn_pin(step_btn_pin),
    .reset_btn_pin(reset_btn_pin), .frame_ok(frame_ok), .start_out(start_out),
    .trip_out(trip_out), .serial_en(serial_en), .baud_tick(baud_tick));

  station_model host (.clk(clk), .rdata(rdata), .bus(bus), .frame_ok(frame_ok));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  //////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic conclude;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is near 52k cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    host.rd(a, q);
    check(q, e);
  endtask

  task automatic run(input int s, input int n);
    stage_start[s] <= 1'b1;
    cy(n);
    stage_start[s] <= 1'b0;
    cy(4);
  endtask

  task automatic drain;
    for (int i = 0; i < 12; i++)
    begin
      host.rd(A_EVT, q);
      if (q[31] === 1'b1 && q[21:16] inside {[6'h1:6'h8]})
        seen[q[21:16] - 6'h1] = 1'b1;
      if (q[31] === 1'b1 && q[21:16] === CODE_OVERFLOW)
        ovf = 1'b1;
    end
  endtask

  task automatic tick_gap(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (baud_tick !== 1'b1 && n < 400);
  endtask

  //////////////////////////////////////////////////
  task automatic t_defaults;
    cy(2);
    check(32'(serial_en), 32'h1);
    rchk(A_MASK, 32'h55);
    rchk(A_BAUD, 32'h4);
    host.rd(A_EVT, q);
    check(32'({q[31], q[21:16]}), 32'({1'b1, CODE_RESTART}));
  endtask

  task automatic t_display;
    for (int i = 0; i < 8; i++)
    begin
      block_pin <= i[1:0];
      remote_reset_pin <= i[2];
      cy(4);
      rchk(A_CTRL, {23'h0, i[2], 6'h0, i[1:0]});
    end
    block_pin <= 2'h0;
    remote_reset_pin <= 1'b0;
  endtask

  task automatic t_testmode;
    logic [3:0] tbl [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
    for (int s = 0; s < 5; s++)
    begin
      host.wr(A_CTRL, 32'(s) << TEST_SEL_LSB);
      cy(3);
      check(32'({trip_out, start_out}), (s == 0) ? 32'h0 : 32'(tbl[s - 1]));
    end
    host.wr(A_CTRL, 32'h0);
  endtask

  task automatic t_link;
    host.frame();
    cy(2);
    rchk(A_MON, 32'h0);
    host.wr(A_NODE, 32'h0);
    cy(2);
    check(32'(serial_en), 32'h0);
    host.frame();
    cy(600);
    host.rd(A_MON, q);
    check(32'(q[7:0] != 8'h0), 32'h1);
    host.wr(A_NODE, 32'h1);
    host.frame();
    cy(2);
    rchk(A_MON, 32'h0);
  endtask

  task automatic t_baud;
    int rate [5] = '{300, 1200, 2400, 4800, 9600};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      host.wr(A_BAUD, 32'(i));
      tick_gap(n);
      tick_gap(n);
      check(32'(n), 32'(HZ / rate[i]));
    end
    host.wr(A_BAUD, 32'h5);
    rchk(A_BAUD, 32'h4);
  endtask

  task automatic t_low;
    logic [31:0] e1;
    drain();
    stage_start[0] <= 1'b1;
    cy(12700);
    check(32'(trip_out[0]), 32'h1);
    rchk(A_DLOW, 32'(PCT_FULL));
    rchk(A_NLOW, 32'h1);
    stage_start[0] <= 1'b0;
    cy(4);
    host.rd(A_EVT, e1);
    host.rd(A_EVT, q);
    check(32'({e1[21:16], q[21:16]}), 32'h043);
    check(32'((q[15:0] - e1[15:0]) inside {[16'd49:16'd51]}), 32'h1);
    stage_start[0] <= 1'b1;
    cy(2);
    rchk(A_DLOW, 32'h0);
    stage_start[0] <= 1'b0;
  endtask

  task automatic t_high;
    host.wr(A_THIGH, 32'h101);
    stage_start[1] <= 1'b1;
    cy(24000);
    check(32'(trip_out[1]), 32'h0);
    cy(1400);
    check(32'(trip_out[1]), 32'h1);
    rchk(A_DHIGH, 32'(PCT_FULL));
    rchk(A_NHIGH, 32'h1);
    stage_start[1] <= 1'b0;
  endtask

  task automatic t_clear;
    u0_level <= 8'h0;
    host.wr(A_CLEAR, 32'h0);
    for (int a = 1; a <= 5; a++)
      rchk(5'(a), 32'h0);
    run(0, 4);
    step_btn_pin <= 1'b1;
    reset_btn_pin <= 1'b1;
    cy(5);
    step_btn_pin <= 1'b0;
    reset_btn_pin <= 1'b0;
    rchk(A_NLOW, 32'h0);
  endtask

  task automatic t_mask;
    host.wr(A_TLOW, 32'h1);
    host.wr(A_THIGH, 32'h1);
    host.wr(A_MASK, 32'hff);
    drain();
    seen = 8'h0;
    run(0, 3000);
    drain();
    run(1, 3000);
    drain();
    check(32'(seen), 32'hff);
    host.wr(A_MASK, 32'h05);
    run(0, 3000);
    host.wr(A_MASK, 32'h0);
    seen = 8'h0;
    drain();
    check(32'(seen), 32'h05);
    block_pin <= 2'h1;
    cy(4);
    run(0, 3000);
    check(32'(trip_out[0]), 32'h0);
    rchk(A_DLOW, 32'(PCT_LAST));
    block_pin <= 2'h0;
    host.wr(A_MASK, 32'hff);
    repeat (6) run(0, 4);
    ovf = 1'b0;
    drain();
    check(32'(ovf), 32'h1);
  endtask

  task automatic t_retain;
    host.wr(A_NODE, 32'h7);
    host.wr(A_BAUD, 32'h2);
    host.wr(A_PASS, 32'h1234);
    rst_n <= 1'b0;
    cy(3);
    rst_n <= 1'b1;
    cy(2);
    rchk(A_NODE, 32'h7);
    rchk(A_BAUD, 32'h2);
    rchk(A_PASS, 32'h1234);
    rchk(A_NLOW, 32'h0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    nv_rst_n = 1'b0;
    remote_reset_pin = 1'b0;
    step_btn_pin = 1'b0;
    reset_btn_pin = 1'b0;
    stage_start = 2'h0;
    block_pin = 2'h0;
    u0_level = 8'h40;
    seen = 8'h0;
    ovf = 1'b0;
    cy(20);
    rst_n <= 1'b1;
    nv_rst_n <= 1'b1;
    t_defaults();
    t_display();
    t_testmode();
    t_link();
    t_baud();
    t_low();
    t_high();
    t_clear();
    t_mask();
    t_retain();
    conclude();
  end
endmodule
